// File: rtl/dfs_regs.vh
// Register offsets, field positions, reset values and timing counts of the fault supervisor
`ifndef DFS_REGS_VH
`define DFS_REGS_VH

// Register byte offsets
`define DFS_CTRL_ADDR        12'h000
`define DFS_LATCH_CFG_ADDR   12'h004
`define DFS_FERR_FLT_ADDR    12'h008
`define DFS_FERR_WARN_ADDR   12'h00c
`define DFS_POS_WIN_ADDR     12'h010
`define DFS_VEL_WIN_ADDR     12'h014
`define DFS_TRACK_TIME_ADDR  12'h018
`define DFS_WIRE_TIME_ADDR   12'h01c
`define DFS_FAULT_ADDR       12'h020
`define DFS_STATUS_ADDR      12'h024
`define DFS_LOG_ADDR         12'h028
`define DFS_POS_ERR_ADDR     12'h02c
`define DFS_VEL_ERR_ADDR     12'h030
`define DFS_CMD_ADDR         12'h034

// Control register fields
`define DFS_CTRL_FERR_DIS    0
`define DFS_CTRL_OVLD_EN     1
`define DFS_CTRL_HALL_EN     2
`define DFS_CTRL_CLR_EN      3
`define DFS_CTRL_RST         32'h0000_0004

// Command register fields (write one to trigger)
`define DFS_CMD_CLR_FAULTS   0
`define DFS_CMD_NEW_TRAJ     1

// Fault vector bit positions
`define DFS_F_SHORT          0
`define DFS_F_DRV_TEMP       1
`define DFS_F_MOT_TEMP       2
`define DFS_F_OVER_V         3
`define DFS_F_UNDER_V        4
`define DFS_F_FEEDBACK       5
`define DFS_F_PHASING        6
`define DFS_F_FERR           7
`define DFS_F_CMD_LOSS       8
`define DFS_F_WIRING         9
`define DFS_F_OVERLOAD       10
`define DFS_NFAULT           11

// Latch configuration reset: short, temps, feedback, following error, overload latch
`define DFS_LATCH_RST        11'h4a7

// Status word bits
`define DFS_S_FERR_WARN      0
`define DFS_S_POS_TRACK      1
`define DFS_S_VEL_TRACK      2
`define DFS_S_FERR_FLT       3
`define DFS_S_VEL_HOLD       4
`define DFS_S_PWM_EN         5
`define DFS_S_BRAKE_REL      6

// Threshold and time reset values (loop updates)
`define DFS_FERR_FLT_RST     32'h0000_1000
`define DFS_FERR_WARN_RST    32'h0000_0800
`define DFS_POS_WIN_RST      32'h0000_0100
`define DFS_VEL_WIN_RST      32'h0000_0100
`define DFS_TRACK_TIME_RST   16'h0010
`define DFS_WIRE_TIME_RST    16'h0010

`endif

// File: rtl/dfs_supervisor.v
// Drive fault supervisor: fault detection, latching, following error and tracking windows
// Notes on behaviour
// - Short circuit or bridge fault raises fault; corrected when short removed.
// - Drive temperature over limit raises fault until it falls below.
// - Motor thermal switch overheating raises fault until switch returns normal.
// - Bus voltage above or below window raises separate over/under faults.
// - Encoder supply overcurrent, missing encoder or bad levels raise feedback fault.
// - Hall/encoder phase mismatch faults only in sinusoidal mode with Hall correction.
// - Loss of pulse-width or network command raises command fault until resumed.
// - No motor current during brake test interval raises wiring fault.
// - Enabled overload reaching current-time limit raises latched fault; reduce current.
// - Six faults latch by default; each configurable non-latching.
// - Position error is limited trajectory position minus measured position.
// - Position error reaching fault threshold raises fault unless disabled.
// - Position error reaching warning threshold sets warning status and output.
// - Velocity error is limited command minus measured; never a fault.
// - Tracking bit sets outside window; clears after staying inside tracking time.
// - Following error fault sets status bit and logs the fault.
// - Non-latched following fault: velocity mode, fast stop, power on, hold zero.
// - New trajectory command clears non-latched following fault.
// - Latched following fault disables power and engages brake at once.
// - Enable off-then-on or clear command clears latched faults.
// - Power-cycle clears latched faults only if both supplies went down.
// - Any other fault disables power stage and logs fault type.
// - Non-latched fault clears itself once corrected, re-enabling power.
//
// The register addresses and register access over APB were left to the implementer.
`include "dfs_regs.vh"

module dfs_supervisor (
    input  wire        REF_CLK_I,
    input  wire        RST_B_I,
    input  wire        PSEL_I,
    input  wire        PENABLE_I,
    input  wire        PWRITE_I,
    input  wire [11:0] PADDR_I,
    input  wire [31:0] PWDATA_I,
    output wire [31:0] PRDATA_O,
    output wire        PREADY_O,
    output wire        PSLVERR_O,
    input  wire        LOOP_TICK_I,
    input  wire        SHORT_DET_I,
    input  wire        DRV_TEMP_HIGH_I,
    input  wire        MOT_TEMP_SW_I,
    input  wire        BUS_OVER_V_I,
    input  wire        BUS_UNDER_V_I,
    input  wire        ENC_SUPPLY_OC_I,
    input  wire        ENC_MISSING_I,
    input  wire        FB_LEVEL_BAD_I,
    input  wire        SINE_COMM_I,
    input  wire        HALL_MISMATCH_I,
    input  wire        PWM_CMD_LOST_I,
    input  wire        NET_CMD_LOST_I,
    input  wire        MOTOR_CURRENT_I,
    input  wire        OVERLOAD_LIMIT_I,
    input  wire        POS_MODE_I,
    input  wire        VEL_MODE_I,
    input  wire [31:0] TRAJ_POS_I,
    input  wire [31:0] MEAS_POS_I,
    input  wire [31:0] VEL_CMD_I,
    input  wire [31:0] MEAS_VEL_I,
    input  wire        ENABLE_IN_I,
    input  wire        NEW_TRAJ_I,
    input  wire        LOGIC_SUPPLY_OK_I,
    input  wire        HIGH_VOLTAGE_SUPPLY_OK_I,
    output wire        PWM_EN_O,
    output wire        BRAKE_RELEASE_O,
    output wire        VEL_HOLD_O,
    output wire        FERR_WARN_O,
    output wire        FAULT_O
);

    // ==========================================================
    // Helpers
    // ==========================================================
    function [31:0] dfs_abs;
        input [31:0] v;
        begin
            dfs_abs = v[31] ? (~v + 32'h0000_0001) : v;
        end
    endfunction

    // ==========================================================
    // Registers
    // ==========================================================
    reg [31:0]              ctrl_ff;
    reg [`DFS_NFAULT-1:0]   latch_cfg_ff;
    reg [31:0]              ferr_flt_ff;
    reg [31:0]              ferr_warn_ff;
    reg [31:0]              pos_win_ff;
    reg [31:0]              vel_win_ff;
    reg [15:0]              track_time_ff;
    reg [15:0]              wire_time_ff;
    reg [`DFS_NFAULT-1:0]   fault_ff;
    reg [`DFS_NFAULT-1:0]   log_ff;
    reg [31:0]              pos_err_ff;
    reg [31:0]              vel_err_ff;
    reg                     warn_ff;
    reg                     pos_track_ff;
    reg                     vel_track_ff;
    reg [15:0]              pos_cnt_ff;
    reg [15:0]              vel_cnt_ff;
    reg                     en_prev_ff;
    reg                     wire_test_ff;
    reg                     wire_seen_ff;
    reg [15:0]              wire_cnt_ff;
    reg                     wire_bad_ff;
    reg                     brake_rel_ff;
    reg                     pwr_down_ff;
    reg                     pwr_prev_ff;
    reg [31:0]              prdata_ff;
    reg                     cmd_clr_ff;
    reg                     cmd_traj_ff;

    wire wr_en = PSEL_I & PENABLE_I & PWRITE_I;
    wire rd_en = PSEL_I & PENABLE_I & ~PWRITE_I;
    wire addr_ok = (PADDR_I[11:2] <= (`DFS_CMD_ADDR >> 2)) && (PADDR_I[1:0] == 2'b00);

    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_ok;
    assign PRDATA_O  = prdata_ff;

    // ==========================================================
    // Fault conditions
    // ==========================================================
    reg [`DFS_NFAULT-1:0] cond;
    wire ferr_latched = latch_cfg_ff[`DFS_F_FERR];
    wire pwr_ok       = LOGIC_SUPPLY_OK_I & HIGH_VOLTAGE_SUPPLY_OK_I;
    wire pwr_both_off = ~LOGIC_SUPPLY_OK_I & ~HIGH_VOLTAGE_SUPPLY_OK_I;
    wire en_cycle     = ctrl_ff[`DFS_CTRL_CLR_EN] & ENABLE_IN_I & ~en_prev_ff;
    wire en_drop      = ~ENABLE_IN_I & en_prev_ff;
    wire pwr_return   = pwr_ok & ~pwr_prev_ff & pwr_down_ff;
    wire clr_latched  = en_cycle | cmd_clr_ff | pwr_return;
    wire traj_clr     = NEW_TRAJ_I | cmd_traj_ff;
    wire [31:0] pos_mag = dfs_abs(pos_err_ff);
    wire [31:0] vel_mag = dfs_abs(vel_err_ff);
    wire ferr_hit = POS_MODE_I && (pos_mag >= ferr_flt_ff) && !ctrl_ff[`DFS_CTRL_FERR_DIS];

    always @* begin
        cond = {`DFS_NFAULT{1'b0}};
        cond[`DFS_F_SHORT]    = SHORT_DET_I;
        cond[`DFS_F_DRV_TEMP] = DRV_TEMP_HIGH_I;
        cond[`DFS_F_MOT_TEMP] = MOT_TEMP_SW_I;
        cond[`DFS_F_OVER_V]   = BUS_OVER_V_I;
        cond[`DFS_F_UNDER_V]  = BUS_UNDER_V_I;
        cond[`DFS_F_FEEDBACK] = ENC_SUPPLY_OC_I | ENC_MISSING_I | FB_LEVEL_BAD_I;
        cond[`DFS_F_PHASING]  = HALL_MISMATCH_I & SINE_COMM_I & ctrl_ff[`DFS_CTRL_HALL_EN];
        cond[`DFS_F_FERR]     = ferr_hit;
        cond[`DFS_F_CMD_LOSS] = PWM_CMD_LOST_I | NET_CMD_LOST_I;
        cond[`DFS_F_WIRING]   = wire_bad_ff;
        cond[`DFS_F_OVERLOAD] = OVERLOAD_LIMIT_I & ctrl_ff[`DFS_CTRL_OVLD_EN];
    end

    // ==========================================================
    // Fault state, set wins over clear
    // ==========================================================
    reg [`DFS_NFAULT-1:0] nxt_fault;
    integer i;
    always @* begin
        nxt_fault = fault_ff;
        for (i = 0; i < `DFS_NFAULT; i = i + 1) begin
            if (i == `DFS_F_FERR) begin
                if (ferr_latched) begin
                    if (clr_latched && !cond[i])
                        nxt_fault[i] = 1'b0;
                end else if (traj_clr || en_drop) begin
                    nxt_fault[i] = 1'b0;
                end
            end else if (latch_cfg_ff[i]) begin
                if (clr_latched && !cond[i])
                    nxt_fault[i] = 1'b0;
            end else begin
                nxt_fault[i] = 1'b0;
            end
            if (cond[i])
                nxt_fault[i] = 1'b1;
        end
    end

    always @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            fault_ff <= {`DFS_NFAULT{1'b0}};
            log_ff   <= {`DFS_NFAULT{1'b0}};
        end else begin
            fault_ff <= nxt_fault;
            log_ff   <= log_ff | cond;
        end
    end

    // ==========================================================
    // Error computation and windows, per loop update
    // ==========================================================
    always @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            pos_err_ff   <= 32'h0000_0000;
            vel_err_ff   <= 32'h0000_0000;
            warn_ff      <= 1'b0;
            pos_track_ff <= 1'b0;
            vel_track_ff <= 1'b0;
            pos_cnt_ff   <= 16'h0000;
            vel_cnt_ff   <= 16'h0000;
        end else if (LOOP_TICK_I) begin
            pos_err_ff <= POS_MODE_I ? (TRAJ_POS_I - MEAS_POS_I) : 32'h0000_0000;
            vel_err_ff <= (POS_MODE_I | VEL_MODE_I) ? (VEL_CMD_I - MEAS_VEL_I) : 32'h0000_0000;
            warn_ff <= POS_MODE_I && (pos_mag >= ferr_warn_ff);
            if (pos_mag > pos_win_ff) begin
                pos_track_ff <= 1'b1;
                pos_cnt_ff   <= 16'h0000;
            end else if (pos_track_ff) begin
                if (pos_cnt_ff + 16'h0001 >= track_time_ff) begin
                    pos_track_ff <= 1'b0;
                    pos_cnt_ff   <= 16'h0000;
                end else begin
                    pos_cnt_ff <= pos_cnt_ff + 16'h0001;
                end
            end
            if (vel_mag > vel_win_ff) begin
                vel_track_ff <= 1'b1;
                vel_cnt_ff   <= 16'h0000;
            end else if (vel_track_ff) begin
                if (vel_cnt_ff + 16'h0001 >= track_time_ff) begin
                    vel_track_ff <= 1'b0;
                    vel_cnt_ff   <= 16'h0000;
                end else begin
                    vel_cnt_ff <= vel_cnt_ff + 16'h0001;
                end
            end
        end
    end

    // ==========================================================
    // Wiring test, enable edge and supply tracking
    // ==========================================================
    wire any_other = |(fault_ff & ~(`DFS_NFAULT'd1 << `DFS_F_FERR));
    wire ferr_lat_act = fault_ff[`DFS_F_FERR] & ferr_latched;
    // Next-state view: brake drops with the fault, enable-clear restarts the test
    wire nxt_block = |(nxt_fault & ~(`DFS_NFAULT'd1 << `DFS_F_FERR)) |
                     (nxt_fault[`DFS_F_FERR] & ferr_latched);

    always @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            en_prev_ff   <= 1'b0;
            wire_test_ff <= 1'b0;
            wire_seen_ff <= 1'b0;
            wire_cnt_ff  <= 16'h0000;
            wire_bad_ff  <= 1'b0;
            brake_rel_ff <= 1'b0;
            pwr_down_ff  <= 1'b0;
            pwr_prev_ff  <= 1'b0;
        end else begin
            en_prev_ff  <= ENABLE_IN_I;
            pwr_prev_ff <= pwr_ok;
            if (pwr_both_off)
                pwr_down_ff <= 1'b1;
            else if (pwr_return)
                pwr_down_ff <= 1'b0;
            if (!ENABLE_IN_I || nxt_block) begin
                brake_rel_ff <= 1'b0;
                wire_test_ff <= 1'b0;
                // Disable withdraws the wiring verdict
                if (!ENABLE_IN_I)
                    wire_bad_ff <= 1'b0;
            end else if (ENABLE_IN_I && !en_prev_ff) begin
                wire_test_ff <= 1'b1;
                wire_seen_ff <= 1'b0;
                wire_cnt_ff  <= wire_time_ff;
            end else if (wire_test_ff) begin
                if (MOTOR_CURRENT_I)
                    wire_seen_ff <= 1'b1;
                if (wire_cnt_ff == 16'h0000) begin
                    wire_test_ff <= 1'b0;
                    brake_rel_ff <= wire_seen_ff | MOTOR_CURRENT_I;
                    wire_bad_ff  <= ~(wire_seen_ff | MOTOR_CURRENT_I);
                end else if (LOOP_TICK_I) begin
                    wire_cnt_ff <= wire_cnt_ff - 16'h0001;
                end
            end
        end
    end

    // other faults disable power, latched following fault
    assign PWM_EN_O        = ENABLE_IN_I & ~any_other & ~ferr_lat_act;
    assign BRAKE_RELEASE_O = brake_rel_ff;
    // non-latched following fault holds zero velocity
    assign VEL_HOLD_O      = fault_ff[`DFS_F_FERR] & ~ferr_latched;
    assign FERR_WARN_O     = warn_ff;
    assign FAULT_O         = |fault_ff;

    // ==========================================================
    // APB register access
    // ==========================================================
    wire [31:0] status = {25'h0, brake_rel_ff, PWM_EN_O, VEL_HOLD_O,
                          fault_ff[`DFS_F_FERR], vel_track_ff, pos_track_ff, warn_ff};

    always @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ctrl_ff       <= `DFS_CTRL_RST;
            latch_cfg_ff  <= `DFS_LATCH_RST;
            ferr_flt_ff   <= `DFS_FERR_FLT_RST;
            ferr_warn_ff  <= `DFS_FERR_WARN_RST;
            pos_win_ff    <= `DFS_POS_WIN_RST;
            vel_win_ff    <= `DFS_VEL_WIN_RST;
            track_time_ff <= `DFS_TRACK_TIME_RST;
            wire_time_ff  <= `DFS_WIRE_TIME_RST;
            cmd_clr_ff    <= 1'b0;
            cmd_traj_ff   <= 1'b0;
            prdata_ff     <= 32'h0000_0000;
        end else begin
            cmd_clr_ff  <= 1'b0;
            cmd_traj_ff <= 1'b0;
            if (wr_en) begin
                if (PADDR_I == `DFS_CTRL_ADDR) begin
                    ctrl_ff <= {28'h0, PWDATA_I[3:0]};
                end else if (PADDR_I == `DFS_LATCH_CFG_ADDR) begin
                    latch_cfg_ff <= PWDATA_I[`DFS_NFAULT-1:0];
                end else if (PADDR_I == `DFS_FERR_FLT_ADDR) begin
                    ferr_flt_ff <= PWDATA_I;
                end else if (PADDR_I == `DFS_FERR_WARN_ADDR) begin
                    ferr_warn_ff <= PWDATA_I;
                end else if (PADDR_I == `DFS_POS_WIN_ADDR) begin
                    pos_win_ff <= PWDATA_I;
                end else if (PADDR_I == `DFS_VEL_WIN_ADDR) begin
                    vel_win_ff <= PWDATA_I;
                end else if (PADDR_I == `DFS_TRACK_TIME_ADDR) begin
                    track_time_ff <= PWDATA_I[15:0];
                end else if (PADDR_I == `DFS_WIRE_TIME_ADDR) begin
                    wire_time_ff <= PWDATA_I[15:0];
                end else if (PADDR_I == `DFS_CMD_ADDR) begin
                    cmd_clr_ff  <= PWDATA_I[`DFS_CMD_CLR_FAULTS];
                    cmd_traj_ff <= PWDATA_I[`DFS_CMD_NEW_TRAJ];
                end
            end
            if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
                if (PADDR_I == `DFS_CTRL_ADDR)
                    prdata_ff <= ctrl_ff;
                else if (PADDR_I == `DFS_LATCH_CFG_ADDR)
                    prdata_ff <= {21'h0, latch_cfg_ff};
                else if (PADDR_I == `DFS_FERR_FLT_ADDR)
                    prdata_ff <= ferr_flt_ff;
                else if (PADDR_I == `DFS_FERR_WARN_ADDR)
                    prdata_ff <= ferr_warn_ff;
                else if (PADDR_I == `DFS_POS_WIN_ADDR)
                    prdata_ff <= pos_win_ff;
                else if (PADDR_I == `DFS_VEL_WIN_ADDR)
                    prdata_ff <= vel_win_ff;
                else if (PADDR_I == `DFS_TRACK_TIME_ADDR)
                    prdata_ff <= {16'h0, track_time_ff};
                else if (PADDR_I == `DFS_WIRE_TIME_ADDR)
                    prdata_ff <= {16'h0, wire_time_ff};
                else if (PADDR_I == `DFS_FAULT_ADDR)
                    prdata_ff <= {21'h0, fault_ff};
                else if (PADDR_I == `DFS_STATUS_ADDR)
                    prdata_ff <= status;
                else if (PADDR_I == `DFS_LOG_ADDR)
                    prdata_ff <= {21'h0, log_ff};
                else if (PADDR_I == `DFS_POS_ERR_ADDR)
                    prdata_ff <= pos_err_ff;
                else if (PADDR_I == `DFS_VEL_ERR_ADDR)
                    prdata_ff <= vel_err_ff;
                else
                    prdata_ff <= 32'h0000_0000;
            end
        end
    end

endmodule // dfs_supervisor

// File: dv/dfs_motor_model.sv
// Motor windings and power stage seen from the supervisor's far side
module dfs_motor_model (
    input  wire logic pwm_en_i,
    input  wire logic wired_i,
    output logic      current_o
);
    timeunit 1ns;
    timeprecision 1ns;
    assign current_o = pwm_en_i & wired_i;
endmodule // dfs_motor_model

// File: dv/dfs_chk.sv
// Port-level assertions for the fault supervisor
module dfs_chk (
    input wire REF_CLK_I,
    input wire RST_B_I,
    input wire SHORT_DET_I,
    input wire DRV_TEMP_HIGH_I,
    input wire MOT_TEMP_SW_I,
    input wire BUS_OVER_V_I,
    input wire ENC_SUPPLY_OC_I,
    input wire PWM_CMD_LOST_I,
    input wire PWM_EN_O,
    input wire BRAKE_RELEASE_O,
    input wire VEL_HOLD_O,
    input wire FAULT_O
);
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RST_B_I);
    // ==========================================
    // Fault detection
    short_set_a: assert property (SHORT_DET_I |=> FAULT_O)
        else $error("short did not raise fault");
    drv_temp_a: assert property (DRV_TEMP_HIGH_I |=> FAULT_O)
        else $error("drive temperature did not raise fault");
    mot_temp_a: assert property (MOT_TEMP_SW_I |=> FAULT_O)
        else $error("motor temperature did not raise fault");
    over_volt_a: assert property (BUS_OVER_V_I |=> !PWM_EN_O)
        else $error("over voltage left power stage on");
    enc_supply_a: assert property (ENC_SUPPLY_OC_I |=> FAULT_O)
        else $error("encoder supply overcurrent did not raise fault");
    cmd_loss_a: assert property (PWM_CMD_LOST_I |=> FAULT_O)
        else $error("command loss did not raise fault");
    // ==========================================
    // Power stage and brake
    fault_gate_a: assert property (FAULT_O && !VEL_HOLD_O |-> !PWM_EN_O)
        else $error("fault left power stage on");
    hold_fault_a: assert property (VEL_HOLD_O |-> FAULT_O)
        else $error("velocity hold without fault");
    brake_rise_a: assert property ($rose(BRAKE_RELEASE_O) |-> PWM_EN_O)
        else $error("brake released without power stage");
endmodule // dfs_chk

bind dfs_supervisor dfs_chk u_dfs_chk (
    .REF_CLK_I(REF_CLK_I), .RST_B_I(RST_B_I), .SHORT_DET_I(SHORT_DET_I),
    .DRV_TEMP_HIGH_I(DRV_TEMP_HIGH_I), .MOT_TEMP_SW_I(MOT_TEMP_SW_I),
    .BUS_OVER_V_I(BUS_OVER_V_I), .ENC_SUPPLY_OC_I(ENC_SUPPLY_OC_I),
    .PWM_CMD_LOST_I(PWM_CMD_LOST_I), .PWM_EN_O(PWM_EN_O),
    .BRAKE_RELEASE_O(BRAKE_RELEASE_O), .VEL_HOLD_O(VEL_HOLD_O), .FAULT_O(FAULT_O)
);

// File: dv/dfs_supervisor_tb.sv
// Self-checking bench for the fault supervisor
`include "dfs_regs.vh"
module dfs_supervisor_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst_b, psel, penable, pwrite, enable, new_traj, sine;
    logic        tick = 1'b0;
    logic        wired, logic_ok, hv_ok, pready, pslverr, pwm_en, brake, vel_hold;
    logic        warn, fault, cur, err;
    logic [1:0]  tcnt = 2'h0;
    logic [11:0] paddr, cond;
    logic [31:0] pwdata, prdata, traj, vcmd, q;
    int          mismatches = 0;
    int          n_tests = 0;
    int          i;
    int          fbit [12] = '{0, 1, 2, 3, 4, 5, 5, 5, 6, 8, 8, 10};

    dfs_supervisor u_dfs_supervisor (
        .REF_CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .LOOP_TICK_I(tick),
        .SHORT_DET_I(cond[0]), .DRV_TEMP_HIGH_I(cond[1]), .MOT_TEMP_SW_I(cond[2]),
        .BUS_OVER_V_I(cond[3]), .BUS_UNDER_V_I(cond[4]), .ENC_SUPPLY_OC_I(cond[5]),
        .ENC_MISSING_I(cond[6]), .FB_LEVEL_BAD_I(cond[7]), .SINE_COMM_I(sine),
        .HALL_MISMATCH_I(cond[8]), .PWM_CMD_LOST_I(cond[9]), .NET_CMD_LOST_I(cond[10]),
        .MOTOR_CURRENT_I(cur), .OVERLOAD_LIMIT_I(cond[11]), .POS_MODE_I(1'b1),
        .VEL_MODE_I(1'b0), .TRAJ_POS_I(traj), .MEAS_POS_I(32'h0), .VEL_CMD_I(vcmd),
        .MEAS_VEL_I(32'h0), .ENABLE_IN_I(enable), .NEW_TRAJ_I(new_traj),
        .LOGIC_SUPPLY_OK_I(logic_ok), .HIGH_VOLTAGE_SUPPLY_OK_I(hv_ok),
        .PWM_EN_O(pwm_en), .BRAKE_RELEASE_O(brake), .VEL_HOLD_O(vel_hold),
        .FERR_WARN_O(warn), .FAULT_O(fault)
    );
    dfs_motor_model u_dfs_motor_model (.pwm_en_i(pwm_en), .wired_i(wired), .current_o(cur));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Control-loop update every fourth clock
    always @(posedge clk) begin
        tcnt <= tcnt + 2'h1;
        tick <= (tcnt == 2'h3);
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        chk(nm, e, q & m);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #(40 * 20000);
        mismatches++;
        final_report();
    end

    initial begin
        {rst_b, psel, penable, pwrite, enable, new_traj, sine} = '0;
        {wired, logic_ok, hv_ok} = 3'h7;
        {paddr, pwdata, traj, vcmd, cond} = '0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        rdc("ctrl", `DFS_CTRL_ADDR, 32'hffff_ffff, `DFS_CTRL_RST);
        rdc("latch_cfg", `DFS_LATCH_CFG_ADDR, 32'hffff_ffff, {21'h0, `DFS_LATCH_RST});
        rdc("ferr_flt", `DFS_FERR_FLT_ADDR, 32'hffff_ffff, `DFS_FERR_FLT_RST);
        apb(12'h038, 1'b1, 32'h1);
        apb(12'h038, 1'b0, 32'h0);
        chk("unmapped_err", 1, err);
        chk("unmapped_data", 0, q);
        $display("test registers done");
        @(posedge clk);
        enable <= 1'b1;
        wt(100);
        chk("brake_release", 1, brake);
        chk("pwm_on", 1, pwm_en);
        $display("test wiring pass done");
        @(posedge clk);
        traj <= 32'h800;
        vcmd <= 32'h1000;
        wt(16);
        chk("warn", 1, warn);
        chk("no_vel_fault", 0, fault);
        rdc("status_track", `DFS_STATUS_ADDR, 32'hf, 32'h7);
        @(posedge clk);
        traj <= 32'h1000;
        wt(16);
        chk("fe_fault", 1, fault);
        chk("fe_pwm", 0, pwm_en);
        chk("fe_brake", 0, brake);
        rdc("fe_vec", `DFS_FAULT_ADDR, 32'hffff_ffff, 32'h80);
        rdc("fe_status", `DFS_STATUS_ADDR, 32'h8, 32'h8);
        rdc("fe_log", `DFS_LOG_ADDR, 32'h80, 32'h80);
        @(posedge clk);
        traj <= 32'h0;
        vcmd <= 32'h0;
        wt(32);
        chk("fe_latched", 1, fault);
        rdc("track_hold", `DFS_STATUS_ADDR, 32'h6, 32'h6);
        apb(`DFS_CMD_ADDR, 1'b1, 32'h1);
        wt(80);
        chk("fe_cleared", 0, fault);
        rdc("track_clear", `DFS_STATUS_ADDR, 32'h6, 32'h0);
        apb(`DFS_CTRL_ADDR, 1'b1, 32'h7);
        @(posedge clk);
        traj <= 32'h1000;
        wt(16);
        chk("fe_disabled", 0, fault);
        apb(`DFS_CTRL_ADDR, 1'b1, 32'h6);
        apb(`DFS_LATCH_CFG_ADDR, 1'b1, 32'h427);
        wt(16);
        chk("hold", 1, vel_hold);
        chk("hold_pwm", 1, pwm_en);
        @(posedge clk);
        traj <= 32'h0;
        wt(8);
        @(posedge clk);
        new_traj <= 1'b1;
        @(posedge clk);
        new_traj <= 1'b0;
        wt(4);
        chk("hold_clear", 0, vel_hold);
        chk("hold_fault_clear", 0, fault);
        for (i = 0; i < 2; i++) begin
            @(posedge clk);
            traj <= 32'h1000;
            wt(16);
            chk("hold_again", 1, vel_hold);
            @(posedge clk);
            traj <= 32'h0;
            wt(8);
            if (i == 0) apb(`DFS_CMD_ADDR, 1'b1, 32'h2);
            else begin
                @(posedge clk);
                enable <= 1'b0;
            end
            wt(2);
            chk("hold_cleared", 0, vel_hold);
        end
        @(posedge clk);
        enable <= 1'b1;
        $display("test following error done");
        @(posedge clk);
        sine <= 1'b1;
        for (i = 0; i < 12; i++) begin
            @(posedge clk);
            cond <= 12'h1 << i;
            wt(2);
            chk("cond_fault", 1, fault);
            rdc("cond_bit", `DFS_FAULT_ADDR, 32'hffff_ffff, 32'h1 << fbit[i]);
            @(posedge clk);
            cond <= 12'h0;
            wt(2);
            chk("cond_hold", (`DFS_LATCH_RST >> fbit[i]) & 1, fault);
            apb(`DFS_CMD_ADDR, 1'b1, 32'h1);
            wt(2);
            chk("cond_clear", 0, fault);
        end
        @(posedge clk);
        sine <= 1'b0;
        cond <= 12'h100;
        wt(2);
        chk("hall_square", 0, fault);
        @(posedge clk);
        cond <= 12'h1;
        @(posedge clk);
        cond <= 12'h0;
        logic_ok <= 1'b0;
        wt(2);
        @(posedge clk);
        logic_ok <= 1'b1;
        wt(2);
        chk("one_supply", 1, fault);
        @(posedge clk);
        {logic_ok, hv_ok} <= 2'h0;
        wt(2);
        @(posedge clk);
        {logic_ok, hv_ok} <= 2'h3;
        wt(2);
        chk("both_supply", 0, fault);
        $display("test fault table done");
        apb(`DFS_CTRL_ADDR, 1'b1, 32'he);
        @(posedge clk);
        cond <= 12'h1;
        wired <= 1'b0;
        @(posedge clk);
        cond <= 12'h0;
        enable <= 1'b0;
        wt(4);
        @(posedge clk);
        enable <= 1'b1;
        wt(100);
        chk("wiring_brake", 0, brake);
        rdc("wiring_vec", `DFS_FAULT_ADDR, 32'hffff_ffff, 32'h200);
        $display("test wiring fault done");
        final_report();
    end
endmodule // dfs_supervisor_tb
